//--- core/gsccr_pkg.sv
// gsccr_pkg: register map, field positions and reset values of the pin, strap and clock bank
// assumes: 32-bit avalon-mm data, each byte-wide register in the low lane of its own word
package gsccr_pkg;
	// register indices, byte address is four times the index
	localparam logic [4:0] DIR_LOW_IDX = 5'h04;
	localparam logic [4:0] DIR_HIGH_IDX = 5'h05;
	localparam logic [4:0] LEVEL_LOW_IDX = 5'h08;
	localparam logic [4:0] LEVEL_HIGH_IDX = 5'h09;
	localparam logic [4:0] STRAP_IDX = 5'h0c;
	localparam logic [4:0] MEM_CLK_IDX = 5'h10;
	localparam logic [4:0] PIX_CLK_IDX = 5'h14;

	// pin counts and field layout
	localparam int PIN_COUNT = 13;
	localparam int LOW_PINS = 8;
	localparam int HIGH_PINS = 5;
	localparam int SHARED_PIN = 12;
	localparam int STRAP_MEDIA_BIT = 7;
	localparam int MEM_DIV_BIT = 4;
	localparam int MEM_SRC_LSB = 0;
	localparam int PIX_DIV_LSB = 4;
	localparam int PIX_SRC_LSB = 0;

	// reset values
	localparam logic [7:0] DIR_LOW_RST = 8'h00;
	localparam logic [4:0] DIR_HIGH_RST = 5'h00;
	localparam logic [12:0] LEVEL_RST = 13'h0000;
	localparam logic [7:0] STRAP_RST = 8'h00;
	localparam logic [12:0] OE_N_RST = 13'h1fff;
	localparam logic [1:0] SRC_RST = 2'h0;
	localparam logic [1:0] PIX_DIV_RST = 2'h0;
	localparam logic MEM_DIV_RST = 1'b0;

	// source codes
	localparam logic [1:0] SRC_PRIMARY = 2'h0;
	localparam logic [1:0] SRC_HOST_BUS = 2'h1;
	localparam logic [1:0] SRC_ALT = 2'h2;
	localparam logic [1:0] SRC_LAST = 2'h3;
endpackage : gsccr_pkg

//--- core/gsccr_tick_div.sv
// gsccr_tick_div: divides a stream of one-cycle enable pulses by ratio_m1_i + 1
// assumes: one clock, synchronous active-low reset, ratio may change at any time
`timescale 1ns/100ps
`default_nettype none
module gsccr_tick_div (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	// pulse stream
	input wire logic tick_i,
	input wire logic [1:0] ratio_m1_i,
	output logic tick_o
);
	logic [1:0] count;
	wire last_tick = (count >= ratio_m1_i); // a lowered ratio ends the period at once
	wire [1:0] next_count = last_tick ? 2'h0 : 2'(count + 2'h1);

	// count source pulses and pass every (ratio_m1_i + 1)th one
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			count <= 2'h0;
			tick_o <= 1'b0;
		end else begin
			tick_o <= tick_i && last_tick;
			if (tick_i) begin
				count <= next_count;
			end
		end
	end

	a_div_pass: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(tick_i && last_tick) |=> tick_o)
		else $error("divider dropped the closing pulse");
	a_div_block: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(!tick_i || !last_tick) |=> !tick_o)
		else $error("divider passed a pulse mid-period");
endmodule : gsccr_tick_div
`default_nettype wire

//--- core/gsccr_regs.sv
// gsccr_regs: pin direction and level, strap snapshot and clock selection registers
// assumes: avalon-mm slave with waitrequest on core_clk_i; pins, straps and clock
// source enables are synchronous to core_clk_i; clock sources arrive as enable pulses
//
// How it works
// - direction bits 7..0 of the low direction register make pins 0..7 outputs when 1.
// - direction bits 4..0 of the high direction register make pins 8..12 outputs when 1.
// - all direction bits clear at reset so every pin starts as an input.
// - an output pin is driven to the value written to its level bit.
// - reading a level bit of an input pin returns the sampled pin state.
// - strap bit seven caught after reset gives pin 12 to the media port power enable.
// - while pin 12 belongs to the media port, its direction and level bits do not reach it.
// - all eight straps are caught once after reset release and read back unchanged.
// - memory clock divide bit set halves the chosen memory clock source.
// - memory clock source 0 is primary, 1 host bus, 2 third input, 3 gives no clock.
// - pixel divide field 0..3 divides the pixel source by 1..4.
// - pixel source 0 is primary, 1 host bus, 2 second input, 3 the memory clock.
//
// Chosen here: the Avalon-MM slave port.
`timescale 1ns/100ps
`default_nettype none
module gsccr_regs #(
	parameter int ADDR_W = 7
) (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	// avalon-mm slave
	input wire logic [ADDR_W-1:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// general-purpose pins
	input wire logic [12:0] pin_in_i,
	output logic [12:0] pin_out_o,
	output logic [12:0] pin_oe_n_o,
	// straps and media port
	input wire logic [7:0] strap_inputs_i,
	input wire logic media_port_power_enable_i,
	// clock source enables
	input wire logic primary_clock_input_i,
	input wire logic second_clock_input_i,
	input wire logic third_clock_input_i,
	input wire logic host_bus_clock_i,
	// derived clock enables
	output logic memory_clock_en_o,
	output logic panel_pixel_clock_o
);
	// register state
	logic [7:0] dir_low;
	logic [4:0] dir_high;
	logic [12:0] level;
	logic [7:0] strap;
	logic strap_taken;
	logic mem_div;
	logic [1:0] mem_src;
	logic [1:0] pix_div;
	logic [1:0] pix_src;

	// pick one pulse stream out of four
	function automatic logic pick_tick(input logic [1:0] sel, input logic [3:0] ticks);
		pick_tick = ticks[sel];
	endfunction : pick_tick

	// true for the seven mapped register indices
	function automatic logic reg_hit(input logic [4:0] i);
		reg_hit = (i == gsccr_pkg::DIR_LOW_IDX) || (i == gsccr_pkg::DIR_HIGH_IDX) ||
			(i == gsccr_pkg::LEVEL_LOW_IDX) || (i == gsccr_pkg::LEVEL_HIGH_IDX) ||
			(i == gsccr_pkg::STRAP_IDX) || (i == gsccr_pkg::MEM_CLK_IDX) ||
			(i == gsccr_pkg::PIX_CLK_IDX);
	endfunction : reg_hit

	// bus decode, one wait cycle then the access completes
	wire req = avs_read_i || avs_write_i;
	wire done = req && !avs_waitrequest_o;
	wire [4:0] idx = avs_address_i[6:2];
	wire wr_lane = done && avs_write_i && avs_byteenable_i[0];
	wire [7:0] wdata = avs_writedata_i[7:0];
	wire wr_dir_low = wr_lane && (idx == gsccr_pkg::DIR_LOW_IDX);
	wire wr_dir_high = wr_lane && (idx == gsccr_pkg::DIR_HIGH_IDX);
	wire wr_level_low = wr_lane && (idx == gsccr_pkg::LEVEL_LOW_IDX);
	wire wr_level_high = wr_lane && (idx == gsccr_pkg::LEVEL_HIGH_IDX);
	wire wr_mem = wr_lane && (idx == gsccr_pkg::MEM_CLK_IDX);
	wire wr_pix = wr_lane && (idx == gsccr_pkg::PIX_CLK_IDX);

	// pin view and ownership of the shared pin
	wire [12:0] dir = {dir_high, dir_low};
	wire media_owns = strap_taken && strap[gsccr_pkg::STRAP_MEDIA_BIT];
	wire [12:0] level_view = (pin_in_i & ~dir) | (level & dir);

	// read multiplexer, unused bits and addresses give zero
	wire [7:0] rd_dir_low = dir_low;
	wire [7:0] rd_dir_high = {3'h0, dir_high};
	wire [7:0] rd_level_low = level_view[7:0];
	wire [7:0] rd_level_high = {3'h0, level_view[12:8]};
	wire [7:0] rd_mem = {3'h0, mem_div, 2'h0, mem_src};
	wire [7:0] rd_pix = {2'h0, pix_div, 2'h0, pix_src};
	wire [7:0] rd_byte =
		(idx == gsccr_pkg::DIR_LOW_IDX) ? rd_dir_low :
		(idx == gsccr_pkg::DIR_HIGH_IDX) ? rd_dir_high :
		(idx == gsccr_pkg::LEVEL_LOW_IDX) ? rd_level_low :
		(idx == gsccr_pkg::LEVEL_HIGH_IDX) ? rd_level_high :
		(idx == gsccr_pkg::STRAP_IDX) ? strap :
		(idx == gsccr_pkg::MEM_CLK_IDX) ? rd_mem :
		(idx == gsccr_pkg::PIX_CLK_IDX) ? rd_pix : 8'h00;
	wire [31:0] next_readdata = {24'h000000, rd_byte};

	// pin drive, shared pin handed to the media port when the strap says so
	wire [12:0] next_pin_out = media_owns ?
		{media_port_power_enable_i, level[11:0]} : level;
	wire [12:0] next_pin_oe_n = media_owns ? {1'b0, ~dir[11:0]} : ~dir;

	// clock source selection
	wire mem_src_tick = pick_tick(mem_src,
		{1'b0, third_clock_input_i, host_bus_clock_i, primary_clock_input_i});
	wire pix_src_tick = pick_tick(pix_src,
		{memory_clock_en_o, second_clock_input_i, host_bus_clock_i,
		primary_clock_input_i});

	// bus handshake and read data
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			avs_waitrequest_o <= 1'b1;
			avs_readdata_o <= 32'h00000000;
		end else begin
			avs_waitrequest_o <= !(req && avs_waitrequest_o);
			if (req && avs_waitrequest_o) begin
				avs_readdata_o <= next_readdata;
			end
		end
	end

	// direction and level registers
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			dir_low <= gsccr_pkg::DIR_LOW_RST;
			dir_high <= gsccr_pkg::DIR_HIGH_RST;
			level <= gsccr_pkg::LEVEL_RST;
		end else begin
			if (wr_dir_low) dir_low <= wdata;
			if (wr_dir_high) dir_high <= wdata[4:0];
			if (wr_level_low) level[7:0] <= wdata;
			if (wr_level_high) level[12:8] <= wdata[4:0];
		end
	end

	// strap snapshot taken on the first edge after reset release
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			strap <= gsccr_pkg::STRAP_RST;
			strap_taken <= 1'b0;
		end else if (!strap_taken) begin
			strap <= strap_inputs_i;
			strap_taken <= 1'b1;
		end
	end

	// clock configuration registers
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			mem_div <= gsccr_pkg::MEM_DIV_RST;
			mem_src <= gsccr_pkg::SRC_RST;
			pix_div <= gsccr_pkg::PIX_DIV_RST;
			pix_src <= gsccr_pkg::SRC_RST;
		end else begin
			if (wr_mem) begin
				mem_div <= wdata[gsccr_pkg::MEM_DIV_BIT];
				mem_src <= wdata[gsccr_pkg::MEM_SRC_LSB +: 2];
			end
			if (wr_pix) begin
				pix_div <= wdata[gsccr_pkg::PIX_DIV_LSB +: 2];
				pix_src <= wdata[gsccr_pkg::PIX_SRC_LSB +: 2];
			end
		end
	end

	// registered pin outputs
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			pin_out_o <= gsccr_pkg::LEVEL_RST;
			pin_oe_n_o <= gsccr_pkg::OE_N_RST; // every pin released while in reset
		end else begin
			pin_out_o <= next_pin_out;
			pin_oe_n_o <= next_pin_oe_n;
		end
	end

	// memory clock: source halved or passed through
	gsccr_tick_div u_mem_div (
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.tick_i(mem_src_tick),
		.ratio_m1_i({1'b0, mem_div}),
		.tick_o(memory_clock_en_o)
	);

	// panel pixel clock: source divided by one to four
	gsccr_tick_div u_pix_div (
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.tick_i(pix_src_tick),
		.ratio_m1_i(pix_div),
		.tick_o(panel_pixel_clock_o)
	);

	// assertions
	sequence s_req_waits;
		req && avs_waitrequest_o;
	endsequence
	sequence s_req_done;
		!avs_waitrequest_o ##1 avs_waitrequest_o;
	endsequence

	a_bus_one_wait: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		s_req_waits |=> s_req_done)
		else $error("bus access did not complete after one wait cycle");
	a_dir_reset: assert property (@(posedge core_clk_i)
		!rst_n_i |=> (dir_low == 8'h00 && dir_high == 5'h00
		&& pin_oe_n_o == gsccr_pkg::OE_N_RST))
		else $error("pins not inputs after reset");
	a_pin_drive: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		##1 (pin_out_o[11:0] == $past(level[11:0])))
		else $error("output level does not follow level register");
	a_pin_dir: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		##1 (pin_oe_n_o[11:0] == ~$past(dir[11:0])))
		else $error("pin enable does not follow direction bit");
	a_level_read: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(s_req_waits and (avs_read_i && idx == gsccr_pkg::LEVEL_LOW_IDX))
		|=> avs_readdata_o[7:0] == (($past(pin_in_i[7:0]) & ~$past(dir_low))
		| ($past(level[7:0]) & $past(dir_low))))
		else $error("level read does not show pin state");
	a_shared_pin: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		media_owns |=> (!pin_oe_n_o[12] && pin_out_o[12] == $past(media_port_power_enable_i)))
		else $error("shared pin not handed to the media port");
	a_strap_hold: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		strap_taken |=> (strap_taken && $stable(strap)))
		else $error("strap snapshot changed");
	a_strap_take: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(rst_n_i && !strap_taken) |=> (strap == $past(strap_inputs_i)))
		else $error("strap snapshot not taken after reset");
	a_mem_reserved: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(mem_src == gsccr_pkg::SRC_LAST) [*2] |=> !memory_clock_en_o)
		else $error("reserved memory source produced a clock");
	a_pix_from_mem: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(pix_src == gsccr_pkg::SRC_LAST && pix_div == 2'h0 && memory_clock_en_o)
		|=> panel_pixel_clock_o)
		else $error("pixel clock does not follow memory clock");
	a_unused_zero: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		avs_readdata_o[31:8] == 24'h000000)
		else $error("upper read data not zero");

	// write path of every pin register
	a_dir_low_write: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		wr_dir_low |=> (dir_low == $past(wdata)))
		else $error("low direction write lost");
	a_dir_high_write: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		wr_dir_high |=> (dir_high == $past(wdata[4:0])))
		else $error("high direction write lost");
	a_level_low_write: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		wr_level_low |=> (level[7:0] == $past(wdata)))
		else $error("low level write lost");
	a_level_high_write: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		wr_level_high |=> (level[12:8] == $past(wdata[4:0])))
		else $error("high level write lost");

	// shared pin left to its own bits when the strap keeps it general purpose
	a_pin12_gpio: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		!media_owns |=> (pin_oe_n_o[12] == !$past(dir_high[4])
		&& pin_out_o[12] == $past(level[12])))
		else $error("shared pin not driven from its own bits");
	a_strap_ro: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(wr_lane && idx == gsccr_pkg::STRAP_IDX) |=> $stable(strap))
		else $error("strap snapshot took a write");

	// undivided memory clock follows the chosen source one cycle later
	a_mem_primary: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(!mem_div && mem_src == gsccr_pkg::SRC_PRIMARY)
		|=> (memory_clock_en_o == $past(primary_clock_input_i)))
		else $error("memory clock does not follow primary input");
	a_mem_host: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(!mem_div && mem_src == gsccr_pkg::SRC_HOST_BUS)
		|=> (memory_clock_en_o == $past(host_bus_clock_i)))
		else $error("memory clock does not follow host bus clock");
	a_mem_third: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(!mem_div && mem_src == gsccr_pkg::SRC_ALT)
		|=> (memory_clock_en_o == $past(third_clock_input_i)))
		else $error("memory clock does not follow third input");

	// undivided pixel clock follows the chosen source one cycle later
	a_pix_primary: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(pix_div == 2'h0 && pix_src == gsccr_pkg::SRC_PRIMARY)
		|=> (panel_pixel_clock_o == $past(primary_clock_input_i)))
		else $error("pixel clock does not follow primary input");
	a_pix_host: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(pix_div == 2'h0 && pix_src == gsccr_pkg::SRC_HOST_BUS)
		|=> (panel_pixel_clock_o == $past(host_bus_clock_i)))
		else $error("pixel clock does not follow host bus clock");
	a_pix_second: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(pix_div == 2'h0 && pix_src == gsccr_pkg::SRC_ALT)
		|=> (panel_pixel_clock_o == $past(second_clock_input_i)))
		else $error("pixel clock does not follow second input");

	// pixel halving: after a pulse the next source pulse is swallowed
	sequence s_pix_half_out;
		pix_div == 2'h1 && panel_pixel_clock_o && !pix_src_tick;
	endsequence
	sequence s_pix_half_next;
		pix_div == 2'h1 && pix_src_tick;
	endsequence
	a_pix_half: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(s_pix_half_out ##1 s_pix_half_next) |=> !panel_pixel_clock_o)
		else $error("halved pixel clock passed two pulses in a row");

	// refused accesses leave the registers alone and read zero
	a_be_ignored: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(done && avs_write_i && !avs_byteenable_i[0])
		|=> ($stable(dir) && $stable(level) && $stable({mem_div, mem_src, pix_div, pix_src})))
		else $error("write without the low lane changed a register");
	a_unmapped_read: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(s_req_waits and (avs_read_i && !reg_hit(idx))) |=> (avs_readdata_o == 32'h00000000))
		else $error("unmapped read not zero");
endmodule : gsccr_regs
`default_nettype wire

//--- verification/gsccr_pin_partner.sv
// gsccr_pin_partner: external devices on the thirteen general-purpose pins
// assumes: the devices drive every pin that the bank leaves as an input
`timescale 1ns/100ps
`default_nettype none
module gsccr_pin_partner (
	// bank side
	input wire logic [12:0] pin_out_i,
	input wire logic [12:0] pin_oe_n_i,
	// device side
	input wire logic [12:0] ext_i,
	output logic [12:0] pin_in_o
);
	// each wire shows whoever drives it
	assign pin_in_o = (pin_out_i & ~pin_oe_n_i) | (ext_i & pin_oe_n_i);
endmodule : gsccr_pin_partner
`default_nettype wire

//--- verification/gsccr_regs_tb_top.sv
// gsccr_regs_tb_top: register, pin, strap and clock divider tests of the bank
// assumes: package, design and pin partner compiled first; one 250 MHz clock
`timescale 1ns/100ps
`default_nettype none
module gsccr_regs_tb_top;
	// bench signals
	logic clk, rst_n, rd_s, wr_s, sp, ss, st, sh, mpe, mclk, pclk, wreq;
	logic [6:0] addr;
	logic [31:0] wdata, rdata, v;
	logic [3:0] be;
	logic [12:0] pin_in, pin_out, oe_n, ext;
	logic [7:0] strap;
	int n_fail, comparisons, nm, np;
	// clock test table: memory config, pixel config, expected pulse counts
	logic [7:0] mcfg [9] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h10, 8'h11, 8'h12, 8'h01, 8'h00};
	logic [7:0] pcfg [9] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h13, 8'h20, 8'h30, 8'h03, 8'h10};
	int em [9] = '{24, 16, 12, 0, 12, 8, 6, 16, 24};
	int ep [9] = '{24, 16, 8, 0, 6, 8, 6, 16, 12};

	// design and pin devices
	gsccr_regs gsccr_regs_i (
		.core_clk_i(clk), .rst_n_i(rst_n), .avs_address_i(addr), .avs_read_i(rd_s),
		.avs_write_i(wr_s), .avs_writedata_i(wdata), .avs_byteenable_i(be),
		.avs_readdata_o(rdata), .avs_waitrequest_o(wreq), .pin_in_i(pin_in),
		.pin_out_o(pin_out), .pin_oe_n_o(oe_n), .strap_inputs_i(strap),
		.media_port_power_enable_i(mpe), .primary_clock_input_i(sp),
		.second_clock_input_i(ss), .third_clock_input_i(st), .host_bus_clock_i(sh),
		.memory_clock_en_o(mclk), .panel_pixel_clock_o(pclk)
	);
	gsccr_pin_partner gsccr_pin_partner_i (
		.pin_out_i(pin_out), .pin_oe_n_i(oe_n), .ext_i(ext), .pin_in_o(pin_in)
	);

	// clock generator
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// verdict and end of run
	task automatic tally_and_finish();
		if (n_fail == 0 && comparisons > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : tally_and_finish

	// compare seen against expected
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	// one avalon access, held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [4:0] idx, input logic [7:0] d);
		int i;
		@(posedge clk);
		addr <= {idx, 2'b00};
		wdata <= {24'h0, d};
		rd_s <= !w;
		wr_s <= w;
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while (wreq !== 1'b0 && i < 20);
		v = rdata;
		rd_s <= 1'b0;
		wr_s <= 1'b0;
		if (wreq !== 1'b0) begin
			n_fail++;
			tally_and_finish();
		end
	endtask : bus

	// read a register and compare the whole word, upper bytes expected zero
	task automatic rc(input logic [4:0] idx, input logic [7:0] e);
		bus(1'b0, idx, 8'h00);
		chk("readdata", v, {24'h0, e});
	endtask : rc

	// synchronous reset with a given strap pattern
	task automatic do_reset(input logic [7:0] s);
		@(posedge clk);
		rst_n <= 1'b0;
		strap <= s;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
	endtask : do_reset

	// source pulses at four rates for 48 cycles, count derived pulses
	task automatic measure();
		nm = 0;
		np = 0;
		for (int i = 0; i < 56; i++) begin
			@(posedge clk);
			if (mclk === 1'b1) nm++;
			if (pclk === 1'b1) np++;
			sp <= (i < 48) && (i % 2 == 0);
			sh <= (i < 48) && (i % 3 == 0);
			st <= (i < 48) && (i % 4 == 0);
			ss <= (i < 48) && (i % 6 == 0);
		end
	endtask : measure

	// main sequence
	initial begin
		rst_n = 1'b0;
		{rd_s, wr_s, sp, ss, st, sh} = '0;
		addr = '0;
		wdata = '0;
		be = 4'h1;
		mpe = 1'b1;
		ext = 13'h1553;
		strap = 8'h5a;
		n_fail = 0;
		comparisons = 0;
		do_reset(8'h5a);
		#1 chk("pin_oe_n_o", oe_n, 13'h1fff);
		rc(gsccr_pkg::DIR_LOW_IDX, 8'h00);
		rc(gsccr_pkg::DIR_HIGH_IDX, 8'h00);
		strap <= 8'h33;
		bus(1'b1, gsccr_pkg::STRAP_IDX, 8'hff);
		rc(gsccr_pkg::STRAP_IDX, 8'h5a);
		rc(5'h01, 8'h00);
		bus(1'b1, gsccr_pkg::DIR_HIGH_IDX, 8'hff);
		rc(gsccr_pkg::DIR_HIGH_IDX, 8'h1f);
		bus(1'b1, gsccr_pkg::DIR_LOW_IDX, 8'ha5);
		be <= 4'h0;
		bus(1'b1, gsccr_pkg::DIR_LOW_IDX, 8'hff);
		be <= 4'h1;
		bus(1'b1, gsccr_pkg::LEVEL_LOW_IDX, 8'h3c);
		bus(1'b1, gsccr_pkg::LEVEL_HIGH_IDX, 8'h0a);
		repeat (2) @(posedge clk);
		#1 chk("pin_oe_n_o", oe_n, 13'h005a);
		chk("pin_out_o", pin_out & 13'h1fa5, 13'h0a24);
		rc(gsccr_pkg::LEVEL_LOW_IDX, 8'h76);
		rc(gsccr_pkg::LEVEL_HIGH_IDX, 8'h0a);
		bus(1'b1, gsccr_pkg::DIR_HIGH_IDX, 8'h00);
		rc(gsccr_pkg::LEVEL_HIGH_IDX, 8'h15);
		// pin 12 handed to the media port by the strap
		do_reset(8'ha5);
		bus(1'b1, gsccr_pkg::LEVEL_HIGH_IDX, 8'h00);
		repeat (2) @(posedge clk);
		#1 chk("pin_oe_n_o 12", oe_n[12], 1'b0);
		chk("pin_out_o 12", pin_out[12], 1'b1);
		@(posedge clk);
		mpe <= 1'b0;
		repeat (2) @(posedge clk);
		#1 chk("pin_out_o 12", pin_out[12], 1'b0);
		// every source and divide code of both clocks
		for (int k = 0; k < 9; k++) begin
			do_reset(8'h5a);
			bus(1'b1, gsccr_pkg::MEM_CLK_IDX, 8'h10);
			bus(1'b1, gsccr_pkg::MEM_CLK_IDX, mcfg[k] | 8'h10);
			bus(1'b1, gsccr_pkg::MEM_CLK_IDX, mcfg[k]);
			bus(1'b1, gsccr_pkg::PIX_CLK_IDX, pcfg[k]);
			measure();
			chk("memory_clock_en_o count", nm, em[k]);
			chk("panel_pixel_clock_o count", np, ep[k]);
		end
		bus(1'b1, gsccr_pkg::MEM_CLK_IDX, 8'hff);
		rc(gsccr_pkg::MEM_CLK_IDX, 8'h13);
		bus(1'b1, gsccr_pkg::PIX_CLK_IDX, 8'hff);
		rc(gsccr_pkg::PIX_CLK_IDX, 8'h33);
		tally_and_finish();
	end
endmodule : gsccr_regs_tb_top
`default_nettype wire
